// ===== design/tcss_pkg.sv
/*
 * Package for the tension command source selector: register map,
 * selector encodings, scaling constants and carrier structs.
 * Assumes a 100 MHz control clock and a plain strobe register port.
 */
package tcss_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SOURCE_CFG = 8'h00;
    localparam logic [7:0] OFS_TENSION_VOL = 8'h04;
    localparam logic [7:0] OFS_TENSION_PER = 8'h08;
    localparam logic [7:0] OFS_BIAS_PCT = 8'h0c;
    localparam logic [7:0] OFS_BIAS_VAL = 8'h10;
    localparam logic [7:0] OFS_GAIN_PCT = 8'h14;
    localparam logic [7:0] OFS_GAIN_VAL = 8'h18;
    localparam logic [7:0] OFS_FILTER_CFG = 8'h1c;
    localparam logic [7:0] OFS_FIELDBUS_TEN = 8'h20;
    localparam logic [7:0] OFS_FIELDBUS_FRQ = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_TENSION_OUT = 8'h2c;

    // Field positions in SOURCE_CFG
    localparam int SRC_LSB = 0;
    localparam int INC_LSB = 4;
    localparam int DANCER_LSB = 8;
    localparam int ALS_LSB = 12;
    localparam int LSC_LSB = 16;
    localparam int TAPER_LSB = 20;
    localparam int DTS_LSB = 24;
    localparam int TERM1_LSB = 28;
    // FILTER_CFG positions
    localparam int HIRES_LSB = 0;
    localparam int FILT_SEL_LSB = 4;
    localparam int FILT_SHIFT_LSB = 8;

    // Reset values
    localparam logic [31:0] RST_SOURCE_CFG = 32'h0000_0000;
    localparam logic [15:0] RST_GAIN_PCT = 16'h0064;     // 100 %
    localparam logic [15:0] RST_GAIN_VAL = 16'h2710;     // 100.00 N at 0.01 N
    localparam logic [3:0] RST_FILT_SHIFT = 4'h2;

    // Assignment codes meaning "tension command" on an analog terminal
    localparam logic [3:0] ASSIGN_TEN_A = 4'h3;
    localparam logic [3:0] ASSIGN_TEN_B = 4'h4;
    localparam logic [3:0] PCT_FULL = 4'h0;
    localparam logic [31:0] PCT_SCALE = 32'h0000_0064;  // 100 %

    // Range limits per increment selection, in increments
    localparam logic [31:0] MAX_INC0 = 32'd50000;        // 500 N / 0.01 N
    localparam logic [31:0] MAX_INC1 = 32'd50000;        // 5000 N / 0.1 N
    localparam logic [31:0] MAX_INC2 = 32'd50000;        // 50000 N / 1 N

    // Input source codes shared by the signal functions
    typedef enum logic [3:0] {
        TCSS_SRC_ANALOG = 4'h0,
        TCSS_SRC_PARAM = 4'h1,
        TCSS_SRC_PULSE = 4'h2,
        TCSS_SRC_REMOTE = 4'h3,
        TCSS_SRC_DIGITAL = 4'h4,
        TCSS_SRC_REMOTE_B = 4'h5,
        TCSS_SRC_PARAM_B = 4'h6
    } tcss_src_type;

    // Raw command inputs
    typedef struct packed {
        logic [15:0] term1;
        logic [15:0] term6;
        logic [15:0] pulse;
        logic [15:0] digital;
        logic digital_16bit;
        logic [15:0] lsc_shaped;
    } tcss_inputs_type;

    // Calibration set
    typedef struct packed {
        logic [15:0] bias_pct;
        logic [15:0] bias_val;
        logic [15:0] gain_pct;
        logic [15:0] gain_val;
    } tcss_cal_type;

endpackage

// ===== design/tcss_calib.sv
/*
 * Two-point linear calibration: maps an input percentage onto the line
 * through (bias_pct, bias_val) and (gain_pct, gain_val).
 * Assumes inputs already in percent of full scale times 100 (0..10000).
 */
`timescale 1ns/1ps
module tcss_calib (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [15:0] in_val,
    input wire tcss_pkg::tcss_cal_type cal,
    input wire logic pass_raw,
    output logic [31:0] out_val,
    output logic invalid
);
    logic [31:0] out_d;
    logic [31:0] out_q;
    logic inv_d;
    logic inv_q;

    // Interpolate; the input percentage carries two implied decimals, calibration percentages are whole
    always_comb
    begin
        logic signed [33:0] span;
        logic signed [33:0] dx;
        logic signed [33:0] dy;
        logic signed [67:0] prod;
        span = 34'($signed({1'b0, cal.gain_pct}) - $signed({1'b0, cal.bias_pct})) * 34'sd100;
        dx = 34'($signed({1'b0, in_val})) - 34'($signed({1'b0, cal.bias_pct})) * 34'sd100;
        dy = 34'($signed({1'b0, cal.gain_val}) - $signed({1'b0, cal.bias_val}));
        prod = 68'(dx * dy);
        inv_d = (cal.bias_val == 16'h0000) && (cal.gain_val == 16'h0000);
        out_d = 32'h0000_0000;
        if (pass_raw && inv_d)
        begin
            out_d = {16'h0000, in_val};
        end
        else if (inv_d || span == 34'sd0)
        begin
            out_d = 32'h0000_0000;
        end
        else
        begin
            prod = prod / 68'(span) + 68'($signed({1'b0, cal.bias_val}));
            out_d = (prod < 0) ? 32'h0000_0000 : prod[31:0];
        end
    end

    // Register the result
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= 32'h0000_0000;
            inv_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
            inv_q <= inv_d;
        end
    end

    assign out_val = out_q;
    assign invalid = inv_q;
endmodule

// ===== design/tcss_filter.sv
/*
 * First-order smoothing filter, y += (x - y) >> shift.
 * Assumes shift 0 means no smoothing.
 */
`timescale 1ns/1ps
module tcss_filter #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [3:0] shift,
    input wire logic [WIDTH-1:0] in_val,
    output logic [WIDTH-1:0] out_val
);
    logic [WIDTH+15:0] acc_d;
    logic [WIDTH+15:0] acc_q;

    // Accumulator carries 16 fraction bits so small steps are not lost
    always_comb
    begin
        logic signed [WIDTH+17:0] diff;
        diff = $signed({2'b00, in_val, 16'h0000}) - $signed({2'b00, acc_q});
        if (shift == 4'h0)
        begin
            acc_d = {in_val, 16'h0000};
        end
        else
        begin
            acc_d = (WIDTH+16)'($signed({2'b00, acc_q}) + (diff >>> shift));
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_q <= '0;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    assign out_val = acc_q[WIDTH+15:16];
endmodule

// ===== design/tcss_top.sv
/*
 * Tension command source selection: picks the tension command from
 * analog, parameter, pulse, fieldbus or digital input, calibrates the
 * analog, pulse and digital inputs, filters the analog one,
 * saturates the command and gates fieldbus write permission.
 * Assumes synchronous inputs on CLK and a strobe register port.
 */
// Contract
// - Source claimed by higher priority gives zero
// - Fixed priority order among signal functions
// - Source 0 uses terminal 1 or 6
// - Analog calibration; both tensions zero invalid
// - Source 1 uses volatile or persistent parameter
// - Pulse calibrated; both tensions zero invalid
// - Fieldbus: 1,6 parameters; 3,5 remote word; source 5 takes FIELDBUS_BUFFER_REF here, not a remote word
// - Digital input calibrated, else passed raw
// - Increment selects resolution and range
// - Switchover lets fieldbus write tension
// - Write permission matrix for fieldbus
// - Tension and frequency never accepted together
// - Zero actual speed source uses shaped command
// - Analog smoothed by selectable filters; one first-order filter here, filter select field not decoded
// - Enable input gates tension control
`timescale 1ns/1ps
module tcss_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Command sources
    input wire tcss_pkg::tcss_inputs_type SOURCES,
    // Control inputs
    input wire logic TORQUE_MODE,
    input wire logic TENSION_ENABLE_IN,
    input wire logic SWITCHOVER_IN,
    input wire logic SWITCHOVER_ASSIGNED,
    input wire logic DRIVE_STOPPED,
    // Fieldbus remote words and buffer
    input wire logic [15:0] REMOTE_WORD_ONE,
    input wire logic [15:0] REMOTE_WORD_TWO,
    input wire logic [15:0] FIELDBUS_BUFFER_REF,
    input wire logic REMOTE_VALID,
    // Results
    output logic [31:0] TENSION_CMD,
    output logic [15:0] ACTUAL_LINE_SPEED,
    output logic TENSION_ACTIVE,
    output logic TENSION_WRITABLE,
    output logic TORQUE_WRITABLE
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [31:0] cfg_q, cfg_d;
    logic [15:0] vol_q, vol_d, per_q, per_d, fbt_q, fbt_d, fbf_q, fbf_d;
    logic [11:0] flt_q, flt_d;
    tcss_pkg::tcss_cal_type cal_q, cal_d;
    logic use_vol_q, use_vol_d, act_q, act_d;
    logic [31:0] rdata_d, rdata_q, cmd_d, cmd_q;
    logic [15:0] als_d, als_q;
    logic twr_d, twr_q, qwr_d, qwr_q;
    logic [15:0] analog_sel, cal_in;
    logic [31:0] cal_out, filt_out;
    logic cal_inv;
    logic [3:0] src, dancer, als, lsc, taper, dts, term1, hires;

    // Reset release through two flip-flops
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign src = cfg_q[tcss_pkg::SRC_LSB +: 4];
    assign dancer = cfg_q[tcss_pkg::DANCER_LSB +: 4];
    assign als = cfg_q[tcss_pkg::ALS_LSB +: 4];
    assign lsc = cfg_q[tcss_pkg::LSC_LSB +: 4];
    assign taper = cfg_q[tcss_pkg::TAPER_LSB +: 4];
    assign dts = cfg_q[tcss_pkg::DTS_LSB +: 4];
    assign term1 = cfg_q[tcss_pkg::TERM1_LSB +: 4];
    assign hires = flt_q[tcss_pkg::HIRES_LSB +: 4];

    // Terminal holds the tension function when assigned 3 or 4
    function automatic logic is_tension_assign(input logic [3:0] code);
        is_tension_assign = (code == tcss_pkg::ASSIGN_TEN_A) || (code == tcss_pkg::ASSIGN_TEN_B);
    endfunction

    // Maps a source selection to the physical input it occupies
    function automatic logic [3:0] phys(input logic [3:0] sel);
        unique case (sel)
            tcss_pkg::TCSS_SRC_PARAM_B: phys = tcss_pkg::TCSS_SRC_PARAM;
            tcss_pkg::TCSS_SRC_REMOTE_B: phys = tcss_pkg::TCSS_SRC_REMOTE;
            default: phys = sel;
        endcase
    endfunction

    // Analog terminal choice; terminal 1 preferred when both assigned
    always_comb
    begin
        if (is_tension_assign(term1))
        begin
            analog_sel = SOURCES.term1;
        end
        else if (is_tension_assign(hires))
        begin
            analog_sel = SOURCES.term6;
        end
        else
        begin
            analog_sel = 16'h0000;
        end
        cal_in = (src == tcss_pkg::TCSS_SRC_PULSE) ? SOURCES.pulse :
                 (src == tcss_pkg::TCSS_SRC_DIGITAL) ?
                 (SOURCES.digital_16bit ? SOURCES.digital : {4'h0, SOURCES.digital[11:0]}) :
                 analog_sel;
    end

    tcss_calib u_calib (
        .clk(CLK),
        .rst_n(rst_n),
        .in_val(cal_in),
        .cal(cal_q),
        .pass_raw(src == tcss_pkg::TCSS_SRC_DIGITAL),
        .out_val(cal_out),
        .invalid(cal_inv)
    );

    tcss_filter #(
        .WIDTH(32)
    ) u_filter (
        .clk(CLK),
        .rst_n(rst_n),
        .shift((src == tcss_pkg::TCSS_SRC_ANALOG) ? flt_q[tcss_pkg::FILT_SHIFT_LSB +: 4] : 4'h0),
        .in_val(cal_out),
        .out_val(filt_out)
    );

    // Register writes, permission matrix and command selection
    always_comb
    begin
        logic conflict;
        logic [31:0] raw;
        logic [31:0] lim;
        logic sw_on;
        conflict = 1'b0;
        raw = 32'h0000_0000;
        lim = 32'h0000_0000;
        sw_on = 1'b0;
        cfg_d = cfg_q;
        vol_d = vol_q;
        per_d = per_q;
        cal_d = cal_q;
        flt_d = flt_q;
        use_vol_d = use_vol_q;
        fbt_d = fbt_q;
        fbf_d = fbf_q;
        act_d = act_q;
        // Enable only latched while stopped
        if (DRIVE_STOPPED)
        begin
            act_d = TENSION_ENABLE_IN && TORQUE_MODE;
        end
        sw_on = SWITCHOVER_ASSIGNED ? SWITCHOVER_IN : act_q;
        twr_d = TORQUE_MODE && sw_on;
        qwr_d = !(TORQUE_MODE && sw_on);
        if (WR)
        begin
            unique case (ADDR)
                tcss_pkg::OFS_SOURCE_CFG: cfg_d = WDATA;
                tcss_pkg::OFS_TENSION_VOL:
                begin
                    vol_d = WDATA[15:0];
                    use_vol_d = 1'b1;
                end
                tcss_pkg::OFS_TENSION_PER:
                begin
                    per_d = WDATA[15:0];
                    use_vol_d = 1'b0;
                end
                tcss_pkg::OFS_BIAS_PCT: cal_d.bias_pct = WDATA[15:0];
                tcss_pkg::OFS_BIAS_VAL: cal_d.bias_val = WDATA[15:0];
                tcss_pkg::OFS_GAIN_PCT: cal_d.gain_pct = WDATA[15:0];
                tcss_pkg::OFS_GAIN_VAL: cal_d.gain_val = WDATA[15:0];
                tcss_pkg::OFS_FILTER_CFG: flt_d = WDATA[11:0];
                tcss_pkg::OFS_FIELDBUS_TEN:
                begin
                    if (twr_q)
                    begin
                        fbt_d = WDATA[15:0];
                    end
                end
                tcss_pkg::OFS_FIELDBUS_FRQ:
                begin
                    if (qwr_q)
                    begin
                        fbf_d = WDATA[15:0];
                    end
                end
                default: ;
            endcase
        end
        // Remote words reach the tension only with write permission
        if (REMOTE_VALID && twr_q && phys(src) == tcss_pkg::TCSS_SRC_REMOTE)
        begin
            fbt_d = (src == tcss_pkg::TCSS_SRC_REMOTE_B) ? FIELDBUS_BUFFER_REF :
                    (REMOTE_WORD_TWO != 16'h0000) ? REMOTE_WORD_TWO : REMOTE_WORD_ONE;
        end
        // Higher-priority functions on the same input take it
        conflict = (phys(src) == phys(dancer)) || (phys(src) == phys(als));
        unique case (src)
            tcss_pkg::TCSS_SRC_PARAM, tcss_pkg::TCSS_SRC_PARAM_B:
                raw = {16'h0000, use_vol_q ? vol_q : per_q};
            tcss_pkg::TCSS_SRC_REMOTE, tcss_pkg::TCSS_SRC_REMOTE_B:
                raw = {16'h0000, fbt_q};
            default: raw = filt_out;
        endcase
        unique case (cfg_q[tcss_pkg::INC_LSB +: 2])
            2'd0: lim = tcss_pkg::MAX_INC0;
            2'd1: lim = tcss_pkg::MAX_INC1;
            default: lim = tcss_pkg::MAX_INC2;
        endcase
        if (conflict || !act_q)
        begin
            cmd_d = 32'h0000_0000;
        end
        else
        begin
            cmd_d = (raw > lim) ? lim : raw;
        end
        // Actual speed follows shaped line speed when its source is zero
        als_d = (als == 4'h0) ? SOURCES.lsc_shaped : als_q;
        rdata_d = 32'h0000_0000;
        if (RD)
        begin
            unique case (ADDR)
                tcss_pkg::OFS_SOURCE_CFG: rdata_d = cfg_q;
                tcss_pkg::OFS_TENSION_VOL: rdata_d = {16'h0000, vol_q};
                tcss_pkg::OFS_TENSION_PER: rdata_d = {16'h0000, per_q};
                tcss_pkg::OFS_BIAS_PCT: rdata_d = {16'h0000, cal_q.bias_pct};
                tcss_pkg::OFS_BIAS_VAL: rdata_d = {16'h0000, cal_q.bias_val};
                tcss_pkg::OFS_GAIN_PCT: rdata_d = {16'h0000, cal_q.gain_pct};
                tcss_pkg::OFS_GAIN_VAL: rdata_d = {16'h0000, cal_q.gain_val};
                tcss_pkg::OFS_FILTER_CFG: rdata_d = {20'h00000, flt_q};
                tcss_pkg::OFS_FIELDBUS_TEN: rdata_d = {16'h0000, fbt_q};
                tcss_pkg::OFS_FIELDBUS_FRQ: rdata_d = {16'h0000, fbf_q};
                tcss_pkg::OFS_STATUS:
                    rdata_d = {27'h0000000, cal_inv, conflict, qwr_q, twr_q, act_q};
                tcss_pkg::OFS_TENSION_OUT: rdata_d = cmd_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_q <= tcss_pkg::RST_SOURCE_CFG;
            vol_q <= 16'h0000;
            per_q <= 16'h0000;
            cal_q <= {16'h0000, 16'h0000, tcss_pkg::RST_GAIN_PCT, tcss_pkg::RST_GAIN_VAL};
            flt_q <= {tcss_pkg::RST_FILT_SHIFT, 8'h00};
            use_vol_q <= 1'b1;
            fbt_q <= 16'h0000;
            fbf_q <= 16'h0000;
            act_q <= 1'b0;
            twr_q <= 1'b0;
            qwr_q <= 1'b1;
            cmd_q <= 32'h0000_0000;
            als_q <= 16'h0000;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            cfg_q <= cfg_d;
            vol_q <= vol_d;
            per_q <= per_d;
            cal_q <= cal_d;
            flt_q <= flt_d;
            use_vol_q <= use_vol_d;
            fbt_q <= fbt_d;
            fbf_q <= fbf_d;
            act_q <= act_d;
            twr_q <= twr_d;
            qwr_q <= qwr_d;
            cmd_q <= cmd_d;
            als_q <= als_d;
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;
    assign TENSION_CMD = cmd_q;
    assign ACTUAL_LINE_SPEED = als_q;
    assign TENSION_ACTIVE = act_q;
    assign TENSION_WRITABLE = twr_q;
    assign TORQUE_WRITABLE = qwr_q;
endmodule

// ===== testbench/tcss_props.sv
/*
 * Port checker for the tension command selector.
 * Assumes it is bound onto tcss_top and sees only its ports.
 */
`timescale 1ns/1ps
module tcss_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Observed ports
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic TORQUE_MODE,
    input wire logic TENSION_ENABLE_IN,
    input wire logic SWITCHOVER_IN,
    input wire logic SWITCHOVER_ASSIGNED,
    input wire logic DRIVE_STOPPED,
    input wire logic [31:0] TENSION_CMD,
    input wire logic TENSION_ACTIVE,
    input wire logic TENSION_WRITABLE,
    input wire logic TORQUE_WRITABLE
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Read data only in the cycle after a read strobe
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data outside read cycle");
    perm_excl_a: assert property (!(TENSION_WRITABLE && TORQUE_WRITABLE))
        else $error("tension and frequency writable together");
    // Long repetitions leave room for the two reset flops after release
    sw_on_perm_a: assert property (
        (SWITCHOVER_ASSIGNED && SWITCHOVER_IN && TORQUE_MODE) [*6] |-> TENSION_WRITABLE)
        else $error("switchover on but tension not writable");
    sw_off_perm_a: assert property (
        (SWITCHOVER_ASSIGNED && !SWITCHOVER_IN) [*6] |-> TORQUE_WRITABLE)
        else $error("switchover off but torque not writable");
    unasg_idle_a: assert property (
        (!SWITCHOVER_ASSIGNED && !TENSION_ACTIVE) [*6] |-> TORQUE_WRITABLE)
        else $error("inactive unassigned but torque not writable");
    unasg_act_a: assert property (
        (!SWITCHOVER_ASSIGNED && TENSION_ACTIVE && TORQUE_MODE) [*3] |-> TENSION_WRITABLE)
        else $error("active unassigned but tension not writable");
    cmd_sat_a: assert property (TENSION_CMD <= 32'd50000)
        else $error("tension command above range");
    inact_zero_a: assert property ((!TENSION_ACTIVE) [*3] |-> TENSION_CMD == 32'h0)
        else $error("command nonzero while inactive");
    act_rise_a: assert property ($rose(TENSION_ACTIVE) |-> $past(TENSION_ENABLE_IN))
        else $error("activated without enable input");
    act_on_a: assert property (
        (TENSION_ENABLE_IN && DRIVE_STOPPED && TORQUE_MODE) [*5] |-> TENSION_ACTIVE)
        else $error("enable held but control inactive");
    // Main scenarios
    cmd_seen_c: cover property (TENSION_ACTIVE && TENSION_CMD != 32'h0);
    ten_wr_c: cover property (TENSION_WRITABLE && SWITCHOVER_ASSIGNED);
    trq_wr_c: cover property (TORQUE_WRITABLE && TENSION_ACTIVE);
endmodule

bind tcss_top tcss_props u_props (.*);

// ===== testbench/tcss_fb_model.sv
/*
 * Fieldbus master model: posts one tension value in a remote word or
 * the buffer word, scaled to the increment selection.
 * Assumes the bench picks the target word, the value and the scale.
 */
`timescale 1ns/1ps
module tcss_fb_model (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic send,
    input wire logic [1:0] target,
    input wire logic inc_sel,
    input wire logic [15:0] newtons,
    // Fieldbus words
    output logic [15:0] word_one,
    output logic [15:0] word_two,
    output logic [15:0] buf_ref,
    output logic valid
);
    logic [15:0] scaled;

    // Whole newtons times 100 at 0.01 N steps, times 10 at 0.1 N steps
    assign scaled = inc_sel ? 16'(newtons * 16'd10) : 16'(newtons * 16'd100);
    // Words change just after the edge; words not in use are cleared
    always @(posedge clk)
    begin
        valid <= send;
        word_one <= (send && target == 2'd0) ? scaled : 16'h0000;
        word_two <= (send && target == 2'd1) ? scaled : 16'h0000;
        buf_ref <= (send && target == 2'd2) ? scaled : 16'h0000;
    end
endmodule

// ===== testbench/tb_top.sv
/*
 * Self-checking bench for the tension command selector.
 * Assumes the strobe register port and the fieldbus model beside it.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, wr_s, rd_s, tmode, en_in, sw_in, sw_asg, stopped, send, m_inc;
    logic rv, act, twr, qwr;
    logic [1:0] tgt;
    logic [7:0] addr;
    logic [15:0] w1, w2, bref, als_o, newt;
    logic [31:0] wdata, rdata, tcmd, d;
    tcss_pkg::tcss_inputs_type src_in;
    int n_fail, total_checks;

    tcss_top u_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .SOURCES(src_in), .TORQUE_MODE(tmode),
        .TENSION_ENABLE_IN(en_in), .SWITCHOVER_IN(sw_in), .SWITCHOVER_ASSIGNED(sw_asg),
        .DRIVE_STOPPED(stopped), .REMOTE_WORD_ONE(w1), .REMOTE_WORD_TWO(w2),
        .FIELDBUS_BUFFER_REF(bref), .REMOTE_VALID(rv), .TENSION_CMD(tcmd),
        .ACTUAL_LINE_SPEED(als_o), .TENSION_ACTIVE(act), .TENSION_WRITABLE(twr),
        .TORQUE_WRITABLE(qwr));
    tcss_fb_model u_fb (.clk(clk), .send(send), .target(tgt), .inc_sel(m_inc),
        .newtons(newt), .word_one(w1), .word_two(w2), .buf_ref(bref), .valid(rv));

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        total_checks++;
        if (seen !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask

    // Strobe drops after one cycle; the idle cycle keeps drivers single per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    task automatic cfg(input logic [15:0] hi, input logic [3:0] als, input logic [3:0] dn,
        input logic [1:0] inc, input logic [3:0] s);
        wr(tcss_pkg::OFS_SOURCE_CFG, {hi, als, dn, 2'b00, inc, s});
    endtask

    // Command settles within three cycles; sampled mid-cycle
    task automatic chk_cmd(input logic [31:0] e);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("tension_cmd", tcmd, e);
        @(posedge clk);
    endtask

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        {wr_s, rd_s, en_in, sw_in, sw_asg, send, m_inc} = '0;
        {tmode, stopped} = 2'b11;
        tgt = 2'd0;
        addr = 8'h00;
        {newt, wdata} = '0;
        src_in = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(tcss_pkg::OFS_GAIN_PCT, d);
        chk("gain_pct", d, 32'h0000_0064);
        rd(tcss_pkg::OFS_GAIN_VAL, d);
        chk("gain_val", d, 32'h0000_2710);
        rd(tcss_pkg::OFS_FILTER_CFG, d);
        chk("filter_cfg", d, 32'h0000_0200);
        rd(8'h30, d);
        chk("unmapped", d, 32'h0);
        $display("test reset values done");
        // Enable changes only while the drive stands still
        en_in <= 1'b1;
        cfg(16'h0000, 4'hf, 4'hf, 2'd0, 4'h1);
        wr(tcss_pkg::OFS_TENSION_VOL, 32'd5000);
        chk_cmd(32'd5000);
        wr(tcss_pkg::OFS_TENSION_PER, 32'd7000);
        chk_cmd(32'd7000);
        for (int i = 0; i < 3; i++)
        begin
            cfg(16'h0000, 4'hf, 4'hf, 2'(i), 4'h1);
            wr(tcss_pkg::OFS_TENSION_VOL, 32'd60000);
            chk_cmd(32'd50000);
        end
        $display("test parameter source done");
        wr(tcss_pkg::OFS_TENSION_VOL, 32'd1234);
        src_in.lsc_shaped <= 16'h0abc;
        cfg(16'h0000, 4'hf, 4'h1, 2'd0, 4'h1);
        chk_cmd(32'd0);
        cfg(16'h0000, 4'h1, 4'hf, 2'd0, 4'h1);
        chk_cmd(32'd0);
        cfg(16'h0000, 4'hf, 4'h1, 2'd0, 4'h6);
        chk_cmd(32'd0);
        cfg(16'h0001, 4'h0, 4'hf, 2'd0, 4'h1);
        chk_cmd(32'd1234);
        chk("line_speed", {16'h0, als_o}, 32'h0000_0abc);
        $display("test priority done");
        for (int i = 0; i < 3; i++)
        begin
            tgt <= 2'(i);
            m_inc <= (i == 1);
            newt <= 16'd123;
            send <= 1'b1;
            cfg(16'h0000, 4'hf, 4'hf, (i == 1) ? 2'd1 : 2'd0, (i == 2) ? 4'h5 : 4'h3);
            chk_cmd((i == 1) ? 32'd1230 : 32'd12300);
        end
        $display("test fieldbus source done");
        wr(tcss_pkg::OFS_GAIN_VAL, 32'd0);
        src_in.digital <= 16'h1234;
        src_in.digital_16bit <= 1'b1;
        src_in.pulse <= 16'd5000;
        src_in.term1 <= 16'd5000;
        cfg(16'h0000, 4'hf, 4'hf, 2'd0, 4'h4);
        chk_cmd(32'h0000_1234);
        src_in.digital_16bit <= 1'b0;
        chk_cmd(32'h0000_0234);
        cfg(16'h0000, 4'hf, 4'hf, 2'd0, 4'h2);
        chk_cmd(32'd0);
        cfg(16'h3000, 4'hf, 4'hf, 2'd0, 4'h0);
        chk_cmd(32'd0);
        wr(tcss_pkg::OFS_GAIN_VAL, 32'd10000);
        wr(tcss_pkg::OFS_FILTER_CFG, 32'h0);
        cfg(16'h0000, 4'hf, 4'hf, 2'd0, 4'h2);
        chk_cmd(32'd5000);
        for (int i = 3; i < 5; i++)
        begin
            cfg({4'(i), 12'h000}, 4'hf, 4'hf, 2'd0, 4'h0);
            chk_cmd(32'd5000);
        end
        src_in.term6 <= 16'd2500;
        cfg(16'h0000, 4'hf, 4'hf, 2'd0, 4'h0);
        wr(tcss_pkg::OFS_FILTER_CFG, 32'h0000_0003);
        chk_cmd(32'd2500);
        wr(tcss_pkg::OFS_FILTER_CFG, 32'h0000_0203);
        src_in.term6 <= 16'd5000;
        // Shift 2 closes a quarter of the gap per cycle: 2500, 3125, 3593.75
        chk_cmd(32'd3593);
        $display("test sampled sources done");
        sw_asg <= 1'b1;
        sw_in <= 1'b1;
        repeat (6) @(negedge clk);
        chk("tension_wr", {31'h0, twr}, 32'h1);
        chk("torque_wr", {31'h0, qwr}, 32'h0);
        @(posedge clk);
        wr(tcss_pkg::OFS_FIELDBUS_TEN, 32'd777);
        wr(tcss_pkg::OFS_FIELDBUS_FRQ, 32'd888);
        rd(tcss_pkg::OFS_FIELDBUS_TEN, d);
        chk("fb_tension", d, 32'd777);
        rd(tcss_pkg::OFS_FIELDBUS_FRQ, d);
        chk("fb_freq", d, 32'd0);
        sw_in <= 1'b0;
        repeat (6) @(negedge clk);
        chk("tension_wr", {31'h0, twr}, 32'h0);
        @(posedge clk);
        wr(tcss_pkg::OFS_FIELDBUS_FRQ, 32'd999);
        wr(tcss_pkg::OFS_FIELDBUS_TEN, 32'd555);
        rd(tcss_pkg::OFS_FIELDBUS_FRQ, d);
        chk("fb_freq", d, 32'd999);
        rd(tcss_pkg::OFS_FIELDBUS_TEN, d);
        chk("fb_tension", d, 32'd777);
        sw_asg <= 1'b0;
        repeat (6) @(negedge clk);
        chk("tension_wr", {31'h0, twr}, 32'h1);
        @(posedge clk);
        en_in <= 1'b0;
        repeat (6) @(negedge clk);
        chk("active", {31'h0, act}, 32'h0);
        chk("torque_wr", {31'h0, qwr}, 32'h1);
        chk("tension_cmd", tcmd, 32'h0);
        // Enable raised while running must not take effect
        @(posedge clk);
        stopped <= 1'b0;
        en_in <= 1'b1;
        repeat (6) @(negedge clk);
        chk("active_run", {31'h0, act}, 32'h0);
        $display("test write permission done");
        report_and_stop();
    end
endmodule
